// ===== scev_core_model.sv
// Processor-side model: counts handler entries on the interrupt level.
// Assumes irq is a level on pclk.
module scev_core_model (
    // Clock, reset, interrupt
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic irq,
    output int        taken
);
    timeunit 1ns;
    timeprecision 1ns;
    logic seen_ff;
    // A still-high line after exit would re-enter; only a rising level counts as new
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_ff <= 1'b0;
            taken   <= 0;
        end else begin
            seen_ff <= irq;
            if (irq && !seen_ff) taken <= taken + 1;
        end
    end
endmodule // scev_core_model

// ===== scev_defines.vh
// Constants for the system-control event and gating block.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef SCEV_DEFINES_VH
`define SCEV_DEFINES_VH
// Register byte offsets
`define SCEV_OFF_RAW      12'h000
`define SCEV_OFF_EN       12'h004
`define SCEV_OFF_MASKED   12'h008
`define SCEV_OFF_CLR      12'h00C
`define SCEV_OFF_GATE     12'h010
`define SCEV_OFF_SLPCFG   12'h014
`define SCEV_OFF_DSLPCFG  12'h018
`define SCEV_OFF_BUSSEL   12'h01C
`define SCEV_OFF_MCLK     12'h020
// Event bit positions
`define SCEV_BIT_PLL_LOCK 0
`define SCEV_BIT_OVERCUR  1
`define SCEV_BIT_IOSC     2
`define SCEV_BIT_MOSC     3
`define SCEV_BIT_REGDROOP 4
`define SCEV_BIT_SUPDROOP 5
`define SCEV_BIT_PLL_FAIL 6
// Field positions
`define SCEV_MCLK_EN_BIT  31
// Reset values
`define SCEV_RST_EN       7'h00
`define SCEV_RST_CFG      32'h00000000
`define SCEV_RST_DIV      8'h00
`define SCEV_RST_BUSSEL   8'h00
`endif

// ===== scev_mclk_div.v
// Programmable divider for the audio master clock.
// Assumes clk_in is sampled synchronously to pclk as a plain input.
`include "scev_defines.vh"
module scev_mclk_div #(
    parameter DIV_W = 8
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Control
    input  wire             enable,
    input  wire [DIV_W-1:0] divisor,
    input  wire             clk_in,
    // Output
    output reg              mclk_out_ff
);
    reg [DIV_W-1:0] cnt_ff;
    reg             clk_in_d_ff;
    reg [DIV_W-1:0] nxt_cnt;
    reg             nxt_mclk;
    wire            in_rise;

    assign in_rise = clk_in & ~clk_in_d_ff;

    // Toggle output every divisor+1 input rises; disabled holds low
    always @* begin
        nxt_cnt  = cnt_ff;
        nxt_mclk = mclk_out_ff;
        if (!enable) begin
            nxt_cnt  = {DIV_W{1'b0}};
            nxt_mclk = 1'b0;
        end else if (in_rise) begin
            if (cnt_ff >= divisor) begin
                nxt_cnt  = {DIV_W{1'b0}};
                nxt_mclk = ~mclk_out_ff;
            end else begin
                nxt_cnt = cnt_ff + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // State registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff      <= {DIV_W{1'b0}};
            mclk_out_ff <= 1'b0;
            clk_in_d_ff <= 1'b0;
        end else begin
            cnt_ff      <= nxt_cnt;
            mclk_out_ff <= nxt_mclk;
            clk_in_d_ff <= clk_in;
        end
    end
endmodule // scev_mclk_div

// ===== scev_sysctl.v
// System-control events, interrupt, clock gating, GPIO bus select and MCLK enable.
// Assumes an APB master on pclk; event inputs are one-cycle or level pulses on pclk.
//
// Notes on behaviour
// - Seven event sources, one status bit each
// - Enabled sources alone reach the interrupt
// - Raw and masked status both readable
// - Written clear mask drops selected sources
// - Deep-sleep gating keeps only marked peripherals
// - Cleared bus-select maps port to APB
// - Set bus-select decodes port on AHB base
// - Divided MCLK, switchable fully off
// - Gating off: sleep clocks equal run
`include "scev_defines.vh"

// Register map, byte offsets, one aligned 32-bit word each:
//   0x000  raw event status, read only, writes ignored
//   0x004  event enables, one bit per source
//   0x008  masked status, read only, writes ignored
//   0x00C  clear mask, write only, reads zero
//   0x010  peripheral clock gating enable in bit 0
//   0x014  sleep clock set, one bit per peripheral
//   0x018  deep-sleep clock set, one bit per peripheral
//   0x01C  port bus select, a set bit moves the port to AHB
//   0x020  divider value in the low byte, output enable in bit 31
//   other offsets answer with an error and zero read data
// Event bits, low to high: PLL locked, regulator overcurrent,
// internal oscillator fail, main oscillator fail, regulator droop,
// supply droop, PLL failure.
// Bus timing: the access cycle is taken while pready is low and the
// answer follows one cycle later, so every transfer has one wait
// state. A write lands at the edge that raises pready; the master
// still holds the request until it sees pready, so nothing is lost.
module scev_sysctl #(
    parameter NUM_EVT    = 7,
    parameter NUM_PERIPH = 32,
    parameter NUM_PORT   = 8,
    parameter DIV_W      = 8
) (
    // Clock and reset
    input  wire                  pclk,
    input  wire                  presetn,
    // APB slave
    input  wire                  psel,
    input  wire                  penable,
    input  wire                  pwrite,
    input  wire [11:0]           paddr,
    input  wire [31:0]           pwdata,
    output reg  [31:0]           prdata_ff,
    output reg                   pready_ff,
    output reg                   pslverr_ff,
    // Event sources
    input  wire                  pll_locked_event,
    input  wire                  regulator_overcurrent_event,
    input  wire                  internal_osc_fail_event,
    input  wire                  main_osc_fail_event,
    input  wire                  regulator_droop_event,
    input  wire                  supply_droop_event,
    input  wire                  pll_failure_event,
    // Power mode and peripheral run enables
    input  wire                  sleep_mode,
    input  wire                  deep_sleep_mode,
    input  wire [NUM_PERIPH-1:0] periph_run_en,
    input  wire [NUM_PERIPH-1:0] periph_wake_req,
    // Audio clock source
    input  wire                  mclk_src,
    // Outputs
    output reg                   irq_ff,
    output reg  [NUM_PERIPH-1:0] periph_clk_en_ff,
    output reg                   wake_ff,
    output reg  [NUM_PORT-1:0]   gpio_apb_sel_ff,
    output reg  [NUM_PORT-1:0]   gpio_ahb_sel_ff,
    output wire                  mclk_out
);
    reg  [NUM_EVT-1:0]    raw_ff;
    reg  [NUM_EVT-1:0]    en_ff;
    reg                   gate_en_ff;
    reg  [NUM_PERIPH-1:0] slp_cfg_ff;
    reg  [NUM_PERIPH-1:0] dslp_cfg_ff;
    reg  [NUM_PORT-1:0]   bussel_ff;
    reg  [DIV_W-1:0]      mclk_div_ff;
    reg                   mclk_en_ff;
    reg  [NUM_EVT-1:0]    nxt_raw;
    reg  [31:0]           nxt_rdata;
    reg                   nxt_err;
    reg  [NUM_PERIPH-1:0] nxt_clk_en;
    wire [NUM_EVT-1:0]    evt_in;
    wire [NUM_EVT-1:0]    masked;
    wire                  wr;
    wire                  rd;
    wire [NUM_EVT-1:0]    clr_mask;
    wire [NUM_PERIPH-1:0] wake_mask;

    // Event vector in fixed bit order
    assign evt_in[`SCEV_BIT_PLL_LOCK] = pll_locked_event;
    assign evt_in[`SCEV_BIT_OVERCUR]  = regulator_overcurrent_event;
    assign evt_in[`SCEV_BIT_IOSC]     = internal_osc_fail_event;
    assign evt_in[`SCEV_BIT_MOSC]     = main_osc_fail_event;
    assign evt_in[`SCEV_BIT_REGDROOP] = regulator_droop_event;
    assign evt_in[`SCEV_BIT_SUPDROOP] = supply_droop_event;
    assign evt_in[`SCEV_BIT_PLL_FAIL] = pll_failure_event;

    // Access phase strobes; slave takes the first access cycle and answers in the second
    // Masking with pready keeps a held request from being taken twice
    assign wr       = psel & penable & pwrite & ~pready_ff;
    assign rd       = psel & penable & ~pwrite & ~pready_ff;
    assign clr_mask = (wr && paddr == `SCEV_OFF_CLR) ? pwdata[NUM_EVT-1:0] : {NUM_EVT{1'b0}};
    assign masked   = raw_ff & en_ff;

    // Without gating any peripheral may wake; with it only the deep-sleep set
    assign wake_mask = gate_en_ff ? dslp_cfg_ff : {NUM_PERIPH{1'b1}};

    // Sticky status: a new event wins over a same-cycle clear
    // A source held high sets its bit again right after a clear,
    // so the handler must remove the cause before it clears
    always @* begin
        nxt_raw = (raw_ff & ~clr_mask) | evt_in;
    end

    // Read mux; unmapped addresses answer with an error and zero data
    always @* begin
        nxt_rdata = 32'h00000000;
        nxt_err   = 1'b0;
        case (paddr)
            `SCEV_OFF_RAW:     nxt_rdata[NUM_EVT-1:0] = raw_ff;
            `SCEV_OFF_EN:      nxt_rdata[NUM_EVT-1:0] = en_ff;
            `SCEV_OFF_MASKED:  nxt_rdata[NUM_EVT-1:0] = masked;
            `SCEV_OFF_CLR:     nxt_rdata = 32'h00000000;
            `SCEV_OFF_GATE:    nxt_rdata[0] = gate_en_ff;
            `SCEV_OFF_SLPCFG:  nxt_rdata[NUM_PERIPH-1:0] = slp_cfg_ff;
            `SCEV_OFF_DSLPCFG: nxt_rdata[NUM_PERIPH-1:0] = dslp_cfg_ff;
            `SCEV_OFF_BUSSEL:  nxt_rdata[NUM_PORT-1:0] = bussel_ff;
            `SCEV_OFF_MCLK: begin
                nxt_rdata[DIV_W-1:0]         = mclk_div_ff;
                nxt_rdata[`SCEV_MCLK_EN_BIT] = mclk_en_ff;
            end
            default:           nxt_err = 1'b1;
        endcase
    end

    // Peripheral clock enables; stored sleep setup unused when gating is off
    // Deep sleep is decoded first, so a core that raises both mode lines
    // gets the deep-sleep set, not the sleep set
    always @* begin
        if (gate_en_ff && deep_sleep_mode)
            nxt_clk_en = periph_run_en & dslp_cfg_ff;
        else if (gate_en_ff && sleep_mode)
            nxt_clk_en = periph_run_en & slp_cfg_ff;
        else
            nxt_clk_en = periph_run_en;
    end

    // Per-port bus routing, one bit per port
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORT; gp = gp + 1) begin : g_port
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    gpio_apb_sel_ff[gp] <= 1'b1;
                    gpio_ahb_sel_ff[gp] <= 1'b0;
                end else begin
                    gpio_apb_sel_ff[gp] <= ~bussel_ff[gp];
                    gpio_ahb_sel_ff[gp] <= bussel_ff[gp];
                end
            end
        end
    endgenerate

    // Registers, bus answer and outputs
    // Reset leaves every source masked and every port on the legacy bus
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_ff           <= {NUM_EVT{1'b0}};
            en_ff            <= `SCEV_RST_EN;
            gate_en_ff       <= 1'b0;
            slp_cfg_ff       <= `SCEV_RST_CFG;
            dslp_cfg_ff      <= `SCEV_RST_CFG;
            bussel_ff        <= `SCEV_RST_BUSSEL;
            mclk_div_ff      <= `SCEV_RST_DIV;
            mclk_en_ff       <= 1'b0;
            prdata_ff        <= 32'h00000000;
            pready_ff        <= 1'b0;
            pslverr_ff       <= 1'b0;
            irq_ff           <= 1'b0;
            periph_clk_en_ff <= {NUM_PERIPH{1'b0}};
            wake_ff          <= 1'b0;
        end else begin
            raw_ff           <= nxt_raw;
            // Request lags status by one edge; a clear shows on the
            // request line one edge after it lands
            irq_ff           <= |(raw_ff & en_ff);
            periph_clk_en_ff <= nxt_clk_en;
            // Only deep-sleep-marked peripherals may wake under gating
            wake_ff          <= deep_sleep_mode && |(periph_wake_req & wake_mask);
            pready_ff        <= wr | rd;
            pslverr_ff       <= (wr | rd) & nxt_err;
            prdata_ff        <= rd ? nxt_rdata : 32'h00000000;
            if (wr) begin
                case (paddr)
                    `SCEV_OFF_EN:      en_ff       <= pwdata[NUM_EVT-1:0];
                    `SCEV_OFF_GATE:    gate_en_ff  <= pwdata[0];
                    `SCEV_OFF_SLPCFG:  slp_cfg_ff  <= pwdata[NUM_PERIPH-1:0];
                    `SCEV_OFF_DSLPCFG: dslp_cfg_ff <= pwdata[NUM_PERIPH-1:0];
                    `SCEV_OFF_BUSSEL:  bussel_ff   <= pwdata[NUM_PORT-1:0];
                    `SCEV_OFF_MCLK: begin
                        mclk_div_ff <= pwdata[DIV_W-1:0];
                        mclk_en_ff  <= pwdata[`SCEV_MCLK_EN_BIT];
                    end
                    default: ;
                endcase
            end
        end
    end

    // Master clock divider; disabled forces the output low
    scev_mclk_div #(
        .DIV_W       (DIV_W)
    ) u_mclk (
        .pclk        (pclk),
        .presetn     (presetn),
        .enable      (mclk_en_ff),
        .divisor     (mclk_div_ff),
        .clk_in      (mclk_src),
        .mclk_out_ff (mclk_out)
    );
endmodule // scev_sysctl

// ===== scev_sysctl_sva.sv
// Checker for scev_sysctl: bus answers, port select, wake and clock-enable relations.
// Assumes it is bound to scev_sysctl, which has a single clock domain.
module scev_sysctl_sva #(
    parameter NUM_PERIPH = 32,
    parameter NUM_PORT   = 8
) (
    // Clock and reset
    input wire logic                  pclk,
    input wire logic                  presetn,
    // Bus
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic [31:0]           prdata_ff,
    input wire logic                  pready_ff,
    input wire logic                  pslverr_ff,
    // Power modes and outputs
    input wire logic                  sleep_mode,
    input wire logic                  deep_sleep_mode,
    input wire logic [NUM_PERIPH-1:0] periph_run_en,
    input wire logic [NUM_PERIPH-1:0] periph_clk_en_ff,
    input wire logic                  wake_ff,
    input wire logic [NUM_PORT-1:0]   gpio_apb_sel_ff,
    input wire logic [NUM_PORT-1:0]   gpio_ahb_sel_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    logic up_ff;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Masks the first edge after reset, when the clock enables still hold reset values
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) up_ff <= 1'b0;
        else up_ff <= 1'b1;
    end
    sequence s_wait; psel && penable && !pready_ff; endsequence
    sequence s_done; pready_ff ##1 !pready_ff; endsequence
    a_one_wait_state: assert property (s_wait |=> s_done) else $error("bus answer late or long");
    a_ready_needs_req: assert property ($rose(pready_ff) |-> $past(psel && penable)) else $error("stray answer");
    a_err_with_ready: assert property (pslverr_ff |-> pready_ff) else $error("error without answer");
    a_rdata_idle_zero: assert property (!pready_ff |-> prdata_ff == 32'h0) else $error("read data outside answer");
    a_port_sel_pair: assert property (gpio_apb_sel_ff == ~gpio_ahb_sel_ff) else $error("port bus select split");
    a_wake_deep_only: assert property (wake_ff |-> $past(deep_sleep_mode)) else $error("wake outside deep sleep");
    a_clk_en_subset: assert property (up_ff |-> (periph_clk_en_ff & ~$past(periph_run_en)) == '0)
        else $error("clock for a stopped peripheral");
    a_run_clocks_all: assert property (up_ff && !$past(sleep_mode) && !$past(deep_sleep_mode)
        |-> periph_clk_en_ff == $past(periph_run_en)) else $error("run clocks differ");
endmodule // scev_sysctl_sva
bind scev_sysctl scev_sysctl_sva #(.NUM_PERIPH(NUM_PERIPH), .NUM_PORT(NUM_PORT)) u_sva (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .sleep_mode(sleep_mode), .deep_sleep_mode(deep_sleep_mode),
    .periph_run_en(periph_run_en), .periph_clk_en_ff(periph_clk_en_ff), .wake_ff(wake_ff),
    .gpio_apb_sel_ff(gpio_apb_sel_ff), .gpio_ahb_sel_ff(gpio_ahb_sel_ff));

// ===== test_system_control_events_and_gating.sv
// Testbench: events and interrupt, status views, clock gating, port bus select, audio clock.
// Assumes the design, checker and core model are compiled first.
module test_system_control_events_and_gating;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, slp, dslp, msrc, serr, pready_ff, pslverr_ff, irq_ff, wake_ff, mo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata_ff, run, wreq, ce, q, raw, en, c, s, d;
    logic [6:0]  ev;
    logic [7:0]  asel, hsel;
    int          errors, tests_run, taken, n;
    scev_sysctl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
        .pll_locked_event(ev[0]), .regulator_overcurrent_event(ev[1]), .internal_osc_fail_event(ev[2]),
        .main_osc_fail_event(ev[3]), .regulator_droop_event(ev[4]), .supply_droop_event(ev[5]),
        .pll_failure_event(ev[6]), .sleep_mode(slp), .deep_sleep_mode(dslp), .periph_run_en(run),
        .periph_wake_req(wreq), .mclk_src(msrc), .irq_ff(irq_ff), .periph_clk_en_ff(ce), .wake_ff(wake_ff),
        .gpio_apb_sel_ff(asel), .gpio_ahb_sel_ff(hsel), .mclk_out(mo));
    scev_core_model u_core (.pclk(pclk), .presetn(presetn), .irq(irq_ff), .taken(taken));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // Audio source clock at half the bus rate
    always @(posedge pclk) msrc <= ~msrc;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One transfer, held until pready is seen high at a rising edge
    // Only the watchdog ends a wait that never sees pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, dt};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready_ff !== 1'b1);
        q = prdata_ff;
        serr = pslverr_ff;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic toggles(input int cyc);
        logic p;
        p = mo;
        n = 0;
        repeat (cyc) begin
            @(posedge pclk);
            if (mo !== p) n++;
            p = mo;
        end
    endtask
    function automatic logic [31:0] exp_clk(input logic g);
        return (g && dslp) ? run & d : (g && slp) ? run & s : run;
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        {psel, penable, pwrite, slp, dslp, msrc, paddr, pwdata, ev, run, wreq, raw} = '0;
        {errors, tests_run, presetn} = '0;
        void'($urandom(51473));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("apb_sel_rst", 32'hFF, {24'h0, asel});
        for (int i = 0; i < 10; i++) begin
            en = (i < 7) ? 32'h7F : {25'h0, 7'($urandom)};
            apb(1'b1, 12'h004, en);
            c = (i < 7) ? 32'h1 << i : {25'h0, 7'($urandom)};
            ev <= c[6:0];
            raw = raw | c;
            @(posedge pclk);
            ev <= 7'h00;
            repeat (2) @(posedge pclk);
            chk("irq", {31'h0, |(raw & en)}, {31'h0, irq_ff});
            apb(1'b0, 12'h000, 32'h0);
            chk("raw", raw, q);
            apb(1'b0, 12'h008, 32'h0);
            chk("masked", raw & en, q);
            c = (i < 7) ? 32'h1 << i : {25'h0, 7'($urandom)};
            apb(1'b1, 12'h00C, c);
            raw = raw & ~c;
            apb(1'b0, 12'h000, 32'h0);
            chk("raw_clr", raw, q);
            chk("irq_clr", {31'h0, |(raw & en)}, {31'h0, irq_ff});
        end
        chk("core_entry", 32'h1, {31'h0, taken > 0});
        apb(1'b0, 12'h040, 32'h0);
        chk("unmapped", 32'h1, {31'h0, serr});
        {s, d} = {$urandom, $urandom};
        {run, wreq} <= {$urandom, $urandom};
        apb(1'b1, 12'h014, s);
        apb(1'b1, 12'h018, d);
        apb(1'b0, 12'h014, 32'h0);
        chk("slp_cfg", s, q);
        apb(1'b0, 12'h018, 32'h0);
        chk("dslp_cfg", d, q);
        for (int g = 0; g < 2; g++) begin
            apb(1'b1, 12'h010, 32'(g));
            for (int m = 0; m < 3; m++) begin
                {slp, dslp} <= {m == 1, m == 2};
                repeat (3) @(posedge pclk);
                chk("clk_en", exp_clk(g[0]), ce);
                chk("wake", {31'h0, dslp && |(wreq & (g ? d : '1))}, {31'h0, wake_ff});
            end
        end
        {slp, dslp} <= 2'b00;
        c = {24'h0, 8'($urandom)};
        apb(1'b1, 12'h01C, c);
        chk("ahb_sel", c, {24'h0, hsel});
        chk("apb_sel", ~c & 32'hFF, {24'h0, asel});
        apb(1'b1, 12'h020, 32'h80000001);
        apb(1'b0, 12'h020, 32'h0);
        chk("mclk_cfg", 32'h80000001, q);
        toggles(64);
        chk("mclk_on", 32'h1, {31'h0, n >= 15 && n <= 17});
        apb(1'b1, 12'h020, 32'h00000001);
        repeat (8) @(posedge pclk);
        toggles(32);
        chk("mclk_off", 32'h0, n + mo);
        tally_and_finish();
    end
endmodule // test_system_control_events_and_gating
